/* rtl/tdf_debug_timer_freeze_control.sv */
// Notes on behaviour
// - freeze-one bit 0: while halted, 1 stops timer two's clock
// - freeze-two bits 18 and 17: while halted, 1 stops timers 17, 16
// - freeze-two bit 16: while halted, 1 stops timer fifteen's clock
// - freeze-two bit 15: while halted, 1 stops timer fourteen's clock
// - freeze-two bit 11: while halted, 1 stops timer one's clock
// - freeze-two sits at 0x0c and reads all zero after power-on
// - cleared only by power-on reset; system reset leaves it alone
// - writes are taken while system reset is asserted
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tdf_debug_timer_freeze_control
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic [31:0] hrdata,
	input  wire logic        sys_resetn,
	input  wire logic        core_halted,
	output var  logic        gate_timer_one,
	output var  logic        gate_timer_two,
	output var  logic        gate_timer_fourteen,
	output var  logic        gate_timer_fifteen,
	output var  logic        gate_timer_sixteen,
	output var  logic        gate_timer_seventeen
);

	// -------------------------------------------------------------
	// decode helpers
	// -------------------------------------------------------------
	function automatic logic addr_hit(input logic [7:0] a,
		input logic [7:0] ofs);
		addr_hit = (a == ofs);
	endfunction

	function automatic logic [5:0] gate_select(input logic [31:0] f1,
		input logic [31:0] f2);
		gate_select = {f2[tdf_pkg::BIT_TIMER_SEVENTEEN],
			f2[tdf_pkg::BIT_TIMER_SIXTEEN],
			f2[tdf_pkg::BIT_TIMER_FIFTEEN],
			f2[tdf_pkg::BIT_TIMER_FOURTEEN],
			f1[tdf_pkg::BIT_TIMER_TWO],
			f2[tdf_pkg::BIT_TIMER_ONE]};
	endfunction

	// -------------------------------------------------------------
	// bus state
	// -------------------------------------------------------------
	logic        wr_pend_q;
	logic        wr_pend_d;
	logic [7:0]  wr_addr_q;
	logic [7:0]  wr_addr_d;
	logic        rd_two_q;
	logic        rd_two_d;
	logic [31:0] freeze_one_q;
	logic [31:0] freeze_one_d;
	logic [31:0] freeze_two_q;
	logic [31:0] freeze_two_d;
	logic [31:0] rdata_d;
	logic [31:0] status_w;
	logic [7:0]  a_addr;
	logic        a_take;
	logic [5:0]  gate_sel;
	logic [5:0]  gate_w;

	assign a_addr = haddr[tdf_pkg::ADDR_W-1:0];
	assign a_take = hsel & hready & htrans[1];

	always_comb
	begin
		status_w = 32'h0000_0000;
		status_w[tdf_pkg::BIT_STAT_HALTED]    = core_halted;
		status_w[tdf_pkg::BIT_STAT_SYS_RESET] = ~sys_resetn;
	end

	// -------------------------------------------------------------
	// next values
	// -------------------------------------------------------------
	// sub-word writes are dropped rather than merged; the register
	// has no byte lanes, so a partial write could only corrupt it
	always_comb
	begin
		wr_pend_d    = a_take & hwrite & (hsize == tdf_pkg::HSIZE_WORD);
		wr_addr_d    = a_addr;
		rd_two_d     = a_take & ~hwrite &
			addr_hit(a_addr, tdf_pkg::OFS_FREEZE_TWO);
		freeze_one_d = freeze_one_q;
		freeze_two_d = freeze_two_q;
		// sys_resetn deliberately plays no part: a debugger may set up
		// freezing while the rest of the chip is held in reset
		if (wr_pend_q)
		begin
			if (addr_hit(wr_addr_q, tdf_pkg::OFS_FREEZE_ONE))
				freeze_one_d = hwdata & tdf_pkg::MASK_FREEZE_ONE;
			if (addr_hit(wr_addr_q, tdf_pkg::OFS_FREEZE_TWO))
				freeze_two_d = hwdata & tdf_pkg::MASK_FREEZE_TWO;
		end
		// read data use the next values so a write right before a read
		// of the same word is seen without a wait state
		rdata_d = 32'h0000_0000;
		if (a_take && !hwrite)
		begin
			if (addr_hit(a_addr, tdf_pkg::OFS_FREEZE_ONE))
				rdata_d = freeze_one_d;
			else if (addr_hit(a_addr, tdf_pkg::OFS_FREEZE_TWO))
				rdata_d = freeze_two_d;
			else if (addr_hit(a_addr, tdf_pkg::OFS_STATUS))
				rdata_d = status_w;
		end
	end

	// -------------------------------------------------------------
	// registers, cleared by power-on reset only
	// -------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q    <= 1'h0;
			wr_addr_q    <= 8'h00;
			rd_two_q     <= 1'h0;
			freeze_one_q <= tdf_pkg::RST_FREEZE_ONE;
			freeze_two_q <= tdf_pkg::RST_FREEZE_TWO;
			hrdata       <= tdf_pkg::RST_RDATA;
			hreadyout    <= 1'h1;
			hresp        <= tdf_pkg::HRESP_OKAY;
		end
		else
		begin
			wr_pend_q    <= wr_pend_d;
			wr_addr_q    <= wr_addr_d;
			rd_two_q     <= rd_two_d;
			freeze_one_q <= freeze_one_d;
			freeze_two_q <= freeze_two_d;
			hrdata       <= rdata_d;
			hreadyout    <= 1'h1;
			hresp        <= tdf_pkg::HRESP_OKAY;
		end
	end

	// -------------------------------------------------------------
	// per-timer gate stages
	// -------------------------------------------------------------
	assign gate_sel = gate_select(freeze_one_q, freeze_two_q);

	generate
		for (genvar i = 0; i < tdf_pkg::NUM_TIMERS; i++)
		begin : g_gate
			tdf_halt_gate u_gate
			(
				.hclk        (hclk),
				.hresetn     (hresetn),
				.core_halted (core_halted),
				.freeze_bit  (gate_sel[i]),
				.gate_q      (gate_w[i])
			);
		end
	endgenerate

	assign gate_timer_one       = gate_w[0];
	assign gate_timer_two       = gate_w[1];
	assign gate_timer_fourteen  = gate_w[2];
	assign gate_timer_fifteen   = gate_w[3];
	assign gate_timer_sixteen   = gate_w[4];
	assign gate_timer_seventeen = gate_w[5];

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_timer_two_gate: assert property (
		core_halted |=> gate_timer_two ==
		$past(freeze_one_q[tdf_pkg::BIT_TIMER_TWO]))
		else $error("timer two gate wrong");

	a_upper_pair_gate: assert property (
		core_halted |=> (gate_timer_seventeen ==
		$past(freeze_two_q[tdf_pkg::BIT_TIMER_SEVENTEEN]))
		&& (gate_timer_sixteen ==
		$past(freeze_two_q[tdf_pkg::BIT_TIMER_SIXTEEN])))
		else $error("timer seventeen or sixteen gate wrong");

	a_timer_fifteen: assert property (
		core_halted |=> gate_timer_fifteen ==
		$past(freeze_two_q[tdf_pkg::BIT_TIMER_FIFTEEN]))
		else $error("timer fifteen gate wrong");

	a_timer_fourteen: assert property (
		core_halted |=> gate_timer_fourteen ==
		$past(freeze_two_q[tdf_pkg::BIT_TIMER_FOURTEEN]))
		else $error("timer fourteen gate wrong");

	a_timer_one_gate: assert property (
		core_halted |=> gate_timer_one ==
		$past(freeze_two_q[tdf_pkg::BIT_TIMER_ONE]))
		else $error("timer one gate wrong");

	a_read_two: assert property (
		rd_two_q |-> hrdata == freeze_two_q)
		else $error("freeze-two read data mismatch");

	a_sysrst_hold: assert property (
		(!sys_resetn && !wr_pend_q) |=> $stable(freeze_two_q))
		else $error("freeze-two changed without a write");

	a_sysrst_write: assert property (
		(!sys_resetn && wr_pend_q &&
		wr_addr_q == tdf_pkg::OFS_FREEZE_TWO) |=>
		freeze_two_q == ($past(hwdata) & tdf_pkg::MASK_FREEZE_TWO))
		else $error("write during system reset not taken");

	a_reserved_zero: assert property (
		(freeze_two_q & ~tdf_pkg::MASK_FREEZE_TWO) == 32'h0000_0000)
		else $error("reserved freeze-two bits set");

	a_gate_release: assert property (
		!core_halted |=> gate_w == 6'h00)
		else $error("gate held after halt ended");

endmodule
`default_nettype wire

/* rtl/tdf_pkg.sv */
`default_nettype none
package tdf_pkg;

	// -------------------------------------------------------------
	// register map (byte offsets within the slave window)
	// -------------------------------------------------------------
	localparam int unsigned ADDR_W           = 8;
	localparam logic [7:0]  OFS_FREEZE_ONE   = 8'h08;
	localparam logic [7:0]  OFS_FREEZE_TWO   = 8'h0c;
	localparam logic [7:0]  OFS_STATUS       = 8'h10;

	// -------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------
	localparam int unsigned BIT_TIMER_TWO       = 0;
	localparam int unsigned BIT_TIMER_ONE       = 11;
	localparam int unsigned BIT_TIMER_FOURTEEN  = 15;
	localparam int unsigned BIT_TIMER_FIFTEEN   = 16;
	localparam int unsigned BIT_TIMER_SIXTEEN   = 17;
	localparam int unsigned BIT_TIMER_SEVENTEEN = 18;
	localparam int unsigned BIT_STAT_HALTED     = 0;
	localparam int unsigned BIT_STAT_SYS_RESET  = 1;

	// gate vector order: one, two, fourteen, fifteen, sixteen, seventeen
	localparam int unsigned NUM_TIMERS = 6;

	// -------------------------------------------------------------
	// writable masks and reset values
	// -------------------------------------------------------------
	localparam logic [31:0] MASK_FREEZE_ONE  = 32'h0000_0001;
	localparam logic [31:0] MASK_FREEZE_TWO  = 32'h0007_8800;
	localparam logic [31:0] RST_FREEZE_ONE   = 32'h0000_0000;
	localparam logic [31:0] RST_FREEZE_TWO   = 32'h0000_0000;
	localparam logic [31:0] RST_RDATA        = 32'h0000_0000;

	// -------------------------------------------------------------
	// bus encodings
	// -------------------------------------------------------------
	localparam logic [2:0]  HSIZE_WORD       = 3'h2;
	localparam logic        HRESP_OKAY       = 1'h0;

endpackage
`default_nettype wire

/* rtl/tdf_halt_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module tdf_halt_gate
(
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic core_halted,
	input  wire logic freeze_bit,
	output var  logic gate_q
);

	logic gate_d;

	always_comb
	begin
		gate_d = core_halted & freeze_bit;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			gate_q <= 1'h0;
		else
			gate_q <= gate_d;
	end

	a_gate_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		(core_halted && freeze_bit) |=> gate_q)
		else $error("gate did not close while halted and frozen");

endmodule
`default_nettype wire

/* tb/tdf_timer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// timer counters, one step per cycle unless gated
// ----------------------------
module tdf_timer_model
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [5:0] gate,
	output var  logic [5:0] running
);
	logic [5:0] running_d;
	// a gated timer holds its count, so it reports no step
	always_comb
		running_d = ~gate;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			running <= 6'h00;
		else
			running <= running_d;
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        sys_resetn;
	logic        core_halted;
	wire  [5:0]  gate;
	logic [5:0]  running;
	logic [31:0] rd;
	int          fails;
	int          n_compared;

	tdf_debug_timer_freeze_control i_tdf_debug_timer_freeze_control
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .sys_resetn(sys_resetn),
		.core_halted(core_halted), .gate_timer_one(gate[0]),
		.gate_timer_two(gate[1]), .gate_timer_fourteen(gate[2]),
		.gate_timer_fifteen(gate[3]), .gate_timer_sixteen(gate[4]),
		.gate_timer_seventeen(gate[5])
	);
	tdf_timer_model i_tdf_timer_model
	(
		.hclk(hclk), .hresetn(hresetn), .gate(gate), .running(running)
	);

	// ----------------------------
	// shared tasks
	// ----------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one single word transfer; hrdata taken at the data phase edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		hsize  <= tdf_pkg::HSIZE_WORD;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask

	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------
	// scenarios
	// ----------------------------
	task automatic t_reset();
		bus(1'b0, tdf_pkg::OFS_FREEZE_TWO, 32'h0);
		check(rd, 32'h0000_0000);
		bus(1'b0, 8'h40, 32'h0);
		check(rd, 32'h0);
		check({26'h0, gate}, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_fields();
		logic [4:0] pos [6];
		logic [7:0] ofs;
		pos = '{5'd11, 5'd0, 5'd15, 5'd16, 5'd17, 5'd18};
		bus(1'b1, tdf_pkg::OFS_FREEZE_TWO, 32'hffff_ffff);
		bus(1'b0, tdf_pkg::OFS_FREEZE_TWO, 32'h0);
		check(rd, 32'h0007_8800);
		bus(1'b1, tdf_pkg::OFS_FREEZE_ONE, 32'hffff_ffff);
		bus(1'b0, tdf_pkg::OFS_FREEZE_ONE, 32'h0);
		check(rd, 32'h0000_0001);
		repeat (2) @(posedge hclk);
		check({26'h0, gate}, 32'h0);
		core_halted <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			ofs = (i == 1) ? tdf_pkg::OFS_FREEZE_ONE :
				tdf_pkg::OFS_FREEZE_TWO;
			bus(1'b1, tdf_pkg::OFS_FREEZE_ONE, 32'h0);
			bus(1'b1, tdf_pkg::OFS_FREEZE_TWO, 32'h0);
			bus(1'b1, ofs, 32'h1 << pos[i]);
			repeat (3) @(posedge hclk);
			check({26'h0, gate}, 32'h1 << i);
			check({26'h0, running}, ~(32'h1 << i) & 32'h3f);
		end
		bus(1'b0, tdf_pkg::OFS_STATUS, 32'h0);
		check(rd, 32'h1 << tdf_pkg::BIT_STAT_HALTED);
		core_halted <= 1'b0;
		repeat (2) @(posedge hclk);
		check({26'h0, gate}, 32'h0);
		$display("test fields done");
	endtask

	task automatic t_sysreset();
		sys_resetn <= 1'b0;
		bus(1'b1, tdf_pkg::OFS_FREEZE_TWO, 32'h0000_0800);
		check({31'h0, hresp}, 32'h0);
		check({31'h0, hreadyout}, 32'h1);
		bus(1'b0, tdf_pkg::OFS_FREEZE_TWO, 32'h0);
		check(rd, 32'h0000_0800);
		bus(1'b0, tdf_pkg::OFS_STATUS, 32'h0);
		check(rd, 32'h1 << tdf_pkg::BIT_STAT_SYS_RESET);
		sys_resetn <= 1'b1;
		bus(1'b0, tdf_pkg::OFS_FREEZE_TWO, 32'h0);
		check(rd, 32'h0000_0800);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, tdf_pkg::OFS_FREEZE_TWO, 32'h0);
		check(rd, 32'h0);
		$display("test system reset done");
	endtask

	// ----------------------------
	// clock, reset, sequence, watchdog
	// ----------------------------
	initial
	begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	initial
	begin
		fails = 0;
		n_compared = 0;
		hresetn = 1'b0;
		sys_resetn = 1'b1;
		core_halted = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_fields();
		t_sysreset();
		close_out();
	end

	initial
	begin
		repeat (2000) @(posedge hclk);
		fails++;
		close_out();
	end
endmodule
`default_nettype wire
